//--- supervisor_pkg.sv
package supervisor_pkg;

   // Clock and timing.
   localparam int unsigned CLK_PERIOD_NS      = 100;
   localparam int unsigned RETRY_PAUSE_NS     = 128000;
   localparam int unsigned RETRY_PAUSE_CYCLES = (RETRY_PAUSE_NS + CLK_PERIOD_NS - 1) /
                                                CLK_PERIOD_NS;
   localparam int unsigned DEGLITCH_NS        = 40000;
   localparam int unsigned DEGLITCH_CYCLES    = (DEGLITCH_NS + CLK_PERIOD_NS - 1) /
                                                CLK_PERIOD_NS;

   // Consecutive limited switching cycles.
   localparam int unsigned RETRY_TRIP_CYCLES  = 32;
   localparam int unsigned LIMIT_FLAG_CYCLES  = 4;

   // Reset values of the sampled control bits.
   localparam logic RETRY_ENABLE_RESET        = 1'h0;
   localparam logic DISCHARGE_ENABLE_RESET    = 1'h1;
   localparam logic TRANSITION_BLANK_RESET    = 1'h0;

   // The window filter starts in the out-of-window state so power-good starts low.
   localparam logic WINDOW_FILTER_RESET       = 1'h1;

   typedef enum logic [2:0] {
      ST_OFF       = 3'h0,
      ST_SOFTSTART = 3'h1,
      ST_RUN       = 3'h3,
      ST_PAUSE     = 3'h2,
      ST_LOCKOUT   = 3'h6
   } conv_state_t;

endpackage : supervisor_pkg

//--- window_filter_if.sv
interface window_filter_if;
   logic raw_fault;
   logic filt_fault;

   modport filter (
      input  raw_fault,
      output filt_fault
   );

   modport user (
      output raw_fault,
      input  filt_fault
   );
endinterface : window_filter_if

//--- window_deglitch.sv
module window_deglitch
   import supervisor_pkg::*;
#(
   parameter int unsigned CYCLES = DEGLITCH_CYCLES
) (
   input  wire logic      clk_sys_i,
   input  wire logic      rst_b_i,
   window_filter_if.filter win
);

   localparam int unsigned CNT_W = $clog2(CYCLES + 1);

   logic [CNT_W-1:0] cnt_reg;
   logic             filt_reg;

   // The output follows the comparator only after it has disagreed for CYCLES clocks.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg  <= '0;
         filt_reg <= WINDOW_FILTER_RESET;
      end else if (win.raw_fault == filt_reg) begin
         cnt_reg <= '0;
      end else if (cnt_reg == CNT_W'(CYCLES - 1)) begin
         cnt_reg  <= '0;
         filt_reg <= win.raw_fault;
      end else begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   assign win.filt_fault = filt_reg;

   chk_filter_follows_raw: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $changed(filt_reg) |-> (filt_reg == $past(win.raw_fault)))
      else $error("Filter changed to a value the comparator did not hold.");

   chk_filter_holds_short: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (win.raw_fault != filt_reg) && (cnt_reg == '0) ##1 (win.raw_fault == filt_reg)
      |=> (filt_reg == $past(filt_reg, 2)))
      else $error("Filter passed a one-cycle glitch.");

endmodule : window_deglitch

//--- fault_supervisor.sv
// Behaviour
// - Supply above upper threshold stops switching and discharges output if enabled.
// - Supply below lower release threshold restarts switching with fresh soft-start.
// - High-side limit turns high side off, low side on, until low-side limit.
// - Retry policy only when its enable bit is one; bit resets disabled.
// - Thirty-two consecutive limited cycles pause switching fixed time, then soft-start again.
// - Each retry trip sets retry flag and holds power-good low until regulated.
// - Retry flag clears only on status read while overload is absent.
// - Retry disabled means continuous cycle-by-cycle limiting with no pause.
// - Continuous mode sets current-limit flag after four consecutive limited cycles.
// - Current-limit flag clears only on status read while overload is absent.
// - Standalone or primary drives power-good as open drain, low or released.
// - Secondary reads power-good as soft-start done, permitting continuous switching.
// - Output outside ninety-five to one hundred five percent window pulls power-good low; a secondary ignores the window.
// - Window result is deglitched, delaying power-good rising edge by deglitch time.
// - With blanking bit set, window result ignored during voltage transitions.
// - Power-good low when disabled, hot, undervolted, overvolted, soft-starting or retrying.
// - Discharge active only with discharge enable set; bit resets to enabled.
module fault_supervisor
   import supervisor_pkg::*;
#(
   parameter int unsigned PAUSE_CYCLES    = RETRY_PAUSE_CYCLES,
   parameter int unsigned FILTER_CYCLES   = DEGLITCH_CYCLES,
   parameter int unsigned TRIP_CYCLES     = RETRY_TRIP_CYCLES,
   parameter int unsigned LIMIT_CYCLES    = LIMIT_FLAG_CYCLES
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_b_i,
   input  wire logic enable_i,
   input  wire logic thermal_shutdown_i,
   input  wire logic uvlo_i,
   input  wire logic supply_over_i,
   input  wire logic supply_release_i,
   input  wire logic softstart_done_i,
   input  wire logic cycle_tick_i,
   input  wire logic pwm_high_i,
   input  wire logic hs_over_limit_i,
   input  wire logic ls_below_limit_i,
   input  wire logic window_fault_i,
   input  wire logic transition_active_i,
   input  wire logic secondary_i,
   input  wire logic status_read_i,
   input  wire logic discharge_enable_i,
   input  wire logic overload_retry_enable_i,
   input  wire logic power_good_transition_blank_i,
   input  wire logic power_good_i,
   output logic      power_good_o,
   output logic      power_good_oe_o,
   output logic      switching_o,
   output logic      hs_gate_o,
   output logic      ls_gate_o,
   output logic      discharge_o,
   output logic      softstart_start_o,
   output logic      ccm_allow_o,
   output logic      overload_retry_flag_o,
   output logic      current_limit_flag_o,
   output logic      supply_overvoltage_lockout_o
);

   localparam int unsigned CNT_W   = $clog2(TRIP_CYCLES + 1);
   localparam int unsigned PAUSE_W = $clog2(PAUSE_CYCLES + 1);

   conv_state_t      state_reg;
   conv_state_t      state_next;
   logic             retry_en_reg;
   logic             discharge_en_reg;
   logic             blank_reg;
   logic             enabled_once_reg;
   logic             hs_off_reg;
   logic             limited_reg;
   logic [CNT_W-1:0] consec_reg;
   logic [PAUSE_W-1:0] pause_reg;
   logic             retry_flag_reg;
   logic             limit_flag_reg;
   logic             pg_oe_reg;
   logic             pg_pin_prev_reg;
   logic             ccm_reg;
   logic             ss_start_reg;
   logic             hs_gate_reg;
   logic             ls_gate_reg;
   logic             discharge_reg;
   logic             fault_off;
   logic             running;
   logic             cycle_limited;
   logic             retry_trip;
   logic             limit_set;
   logic             overload;
   logic             window_low;
   logic             pg_low;

   window_filter_if win ();

   window_deglitch #(
      .CYCLES (FILTER_CYCLES)
   ) u_deglitch (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .win       (win.filter)
   );

   assign win.raw_fault = window_fault_i;

   // Control bits are sampled so that their reset values are defined.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         retry_en_reg     <= RETRY_ENABLE_RESET;
         discharge_en_reg <= DISCHARGE_ENABLE_RESET;
         blank_reg        <= TRANSITION_BLANK_RESET;
      end else begin
         retry_en_reg     <= overload_retry_enable_i;
         discharge_en_reg <= discharge_enable_i;
         blank_reg        <= power_good_transition_blank_i;
      end
   end

   assign fault_off     = !enable_i || thermal_shutdown_i || uvlo_i;
   assign running       = (state_reg == ST_SOFTSTART) || (state_reg == ST_RUN);
   assign cycle_limited = limited_reg || hs_over_limit_i;
   assign retry_trip    = running && cycle_tick_i && cycle_limited && retry_en_reg &&
                          (consec_reg == CNT_W'(TRIP_CYCLES - 1));
   assign limit_set     = running && cycle_tick_i && cycle_limited && !retry_en_reg &&
                          (consec_reg >= CNT_W'(LIMIT_CYCLES - 1));
   assign overload      = (consec_reg != '0) || (state_reg == ST_PAUSE);

   always_comb begin
      state_next = state_reg;
      if (fault_off) begin
         state_next = ST_OFF;
      end else if (supply_over_i) begin
         state_next = ST_LOCKOUT;
      end else begin
         unique case (state_reg)
            ST_OFF: begin
               state_next = ST_SOFTSTART;
            end
            ST_LOCKOUT: begin
               if (supply_release_i) begin
                  state_next = ST_SOFTSTART;
               end
            end
            ST_SOFTSTART: begin
               if (retry_trip) begin
                  state_next = ST_PAUSE;
               end else if (softstart_done_i) begin
                  state_next = ST_RUN;
               end
            end
            ST_RUN: begin
               if (retry_trip) begin
                  state_next = ST_PAUSE;
               end
            end
            ST_PAUSE: begin
               if (pause_reg == PAUSE_W'(PAUSE_CYCLES - 1)) begin
                  state_next = ST_SOFTSTART;
               end
            end
            default: begin
               state_next = ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg    <= ST_OFF;
         ss_start_reg <= 1'h0;
      end else begin
         state_reg    <= state_next;
         ss_start_reg <= (state_next == ST_SOFTSTART) && (state_reg != ST_SOFTSTART);
      end
   end

   // The pause is counted on the device clock, not on switching ticks.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pause_reg <= '0;
      end else if (state_reg == ST_PAUSE) begin
         pause_reg <= pause_reg + PAUSE_W'(1);
      end else begin
         pause_reg <= '0;
      end
   end

   // Marks a switching cycle in which the high-side limit was reached.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         limited_reg <= 1'h0;
      end else if (cycle_tick_i) begin
         limited_reg <= 1'h0;
      end else if (hs_over_limit_i) begin
         limited_reg <= 1'h1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         consec_reg <= '0;
      end else if (!running || retry_trip) begin
         consec_reg <= '0;
      end else if (cycle_tick_i) begin
         if (!cycle_limited) begin
            consec_reg <= '0;
         end else if (consec_reg != CNT_W'(TRIP_CYCLES)) begin
            consec_reg <= consec_reg + CNT_W'(1);
         end
      end
   end

   // High side stays off from the limit until current falls below the low-side limit.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hs_off_reg <= 1'h0;
      end else if (hs_over_limit_i) begin
         hs_off_reg <= 1'h1;
      end else if (ls_below_limit_i) begin
         hs_off_reg <= 1'h0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hs_gate_reg <= 1'h0;
         ls_gate_reg <= 1'h0;
      end else begin
         hs_gate_reg <= running && pwm_high_i && !hs_over_limit_i && !hs_off_reg;
         ls_gate_reg <= running && (!pwm_high_i || hs_over_limit_i || hs_off_reg);
      end
   end

   // Discharge only makes sense once the converter has been enabled at least once.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         enabled_once_reg <= 1'h0;
         discharge_reg    <= 1'h0;
      end else begin
         if (running) begin
            enabled_once_reg <= 1'h1;
         end
         discharge_reg <= discharge_en_reg && enabled_once_reg &&
                          ((state_reg == ST_OFF) || (state_reg == ST_LOCKOUT));
      end
   end

   // A new event wins over a clearing read in the same cycle.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         retry_flag_reg <= 1'h0;
         limit_flag_reg <= 1'h0;
      end else begin
         if (retry_trip) begin
            retry_flag_reg <= 1'h1;
         end else if (status_read_i && !overload) begin
            retry_flag_reg <= 1'h0;
         end
         if (limit_set) begin
            limit_flag_reg <= 1'h1;
         end else if (status_read_i && !overload) begin
            limit_flag_reg <= 1'h0;
         end
      end
   end

   assign window_low = win.filt_fault && !(blank_reg && transition_active_i);
   assign pg_low     = (state_reg != ST_RUN) || window_low;

   // A secondary pulls low until its own start-up is done, then only listens.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pg_oe_reg       <= 1'h1;
         pg_pin_prev_reg <= 1'h0;
         ccm_reg         <= 1'h0;
      end else begin
         pg_oe_reg       <= secondary_i ? (state_reg != ST_RUN) : pg_low;
         pg_pin_prev_reg <= power_good_i;
         if (!running) begin
            ccm_reg <= 1'h0;
         end else if (!secondary_i) begin
            ccm_reg <= 1'h1;
         end else if (power_good_i && !pg_pin_prev_reg && !pg_oe_reg) begin
            ccm_reg <= 1'h1;
         end
      end
   end

   assign power_good_o                 = 1'h0;
   assign power_good_oe_o              = pg_oe_reg;
   assign switching_o                  = running;
   assign hs_gate_o                    = hs_gate_reg;
   assign ls_gate_o                    = ls_gate_reg;
   assign discharge_o                  = discharge_reg;
   assign softstart_start_o            = ss_start_reg;
   assign ccm_allow_o                  = ccm_reg;
   assign overload_retry_flag_o        = retry_flag_reg;
   assign current_limit_flag_o         = limit_flag_reg;
   assign supply_overvoltage_lockout_o = (state_reg == ST_LOCKOUT);

   chk_lockout_stops: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      supply_over_i |=> !switching_o ##1
      (discharge_o == $past(discharge_en_reg && enabled_once_reg)))
      else $error("Overvoltage did not stop switching or set discharge.");

   chk_lockout_release: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (state_reg == ST_LOCKOUT) && supply_release_i && !supply_over_i && !fault_off
      |=> (state_reg == ST_SOFTSTART) ##0 softstart_start_o)
      else $error("Release from overvoltage lockout did not start soft-start.");

   chk_hs_limit_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      hs_over_limit_i ##1 !ls_below_limit_i |=> !hs_gate_o ##0 (ls_gate_o == $past(running)))
      else $error("High side not held off after current limit.");

   chk_retry_pause: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      retry_trip && !fault_off && !supply_over_i |=> (state_reg == ST_PAUSE) ##0 !switching_o)
      else $error("Retry trip did not pause switching.");

   chk_pause_length: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (state_reg == ST_PAUSE) |-> (pause_reg <= PAUSE_W'(PAUSE_CYCLES - 1)))
      else $error("Retry pause ran longer than its fixed time.");

   chk_pause_needs_en: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(state_reg == ST_PAUSE) |-> $past(retry_en_reg) && $past(consec_reg) == CNT_W'(TRIP_CYCLES - 1))
      else $error("Pause entered without retry policy or full count.");

   chk_retry_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      retry_trip |=> overload_retry_flag_o ##1 (power_good_oe_o || secondary_i))
      else $error("Retry trip did not set flag and pull power-good low.");

   chk_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      status_read_i && !overload && !retry_trip && !limit_set
      |=> !overload_retry_flag_o && !current_limit_flag_o)
      else $error("Status read with no overload did not clear flags.");

   chk_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      current_limit_flag_o && !(status_read_i && !overload) |=> current_limit_flag_o)
      else $error("Current-limit flag dropped without a qualifying read.");

   chk_limit_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      limit_set |=> current_limit_flag_o ##0 (state_reg != ST_PAUSE))
      else $error("Current-limit flag not set after four limited cycles.");

   chk_pg_forced_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !secondary_i && (state_reg != ST_RUN) |=> power_good_oe_o)
      else $error("Power-good released outside regulation state.");

   chk_pg_window: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !secondary_i && (state_reg == ST_RUN) && !(win.filt_fault && !(blank_reg && transition_active_i))
      |=> !power_good_oe_o)
      else $error("Power-good held low while in window or blanked.");

endmodule : fault_supervisor

//--- stage_model.sv
module stage_model (
   input  wire logic clk_sys_i,
   input  wire logic rst_b_i,
   input  wire logic overload_i,
   input  wire logic hs_gate_i,
   input  wire logic power_good_oe_i,
   output logic      hs_over_limit_o,
   output logic      ls_below_limit_o,
   output logic      cycle_tick_o,
   output logic      power_good_wire_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [2:0] tick_cnt_reg;
   logic [1:0] decay_reg;

   // A switching cycle boundary comes every eight clocks.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_cnt_reg <= 3'h0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 3'h1;
      end
   end
   assign cycle_tick_o = (tick_cnt_reg == 3'h7);

   // Under overload the current trips the limit while the high side conducts.
   // It then needs two clocks of low-side conduction to fall below the low limit.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         decay_reg <= 2'h0;
      end else if (overload_i && hs_gate_i) begin
         decay_reg <= 2'h2;
      end else if (decay_reg != 2'h0) begin
         decay_reg <= decay_reg - 2'h1;
      end
   end
   assign hs_over_limit_o  = (decay_reg == 2'h2);
   assign ls_below_limit_o = (decay_reg == 2'h0);

   // The power-good wire has a pull-up, so a released pin reads high.
   assign power_good_wire_o = power_good_oe_i ? 1'b0 : 1'b1;
endmodule : stage_model

//--- converter_fault_power_good_supervisor_test.sv
module converter_fault_power_good_supervisor_test
   import supervisor_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int unsigned PAUSE = 20;
   localparam int unsigned FILT  = 4;

   logic clk_sys_i, rst_b_i, enable_i, thermal_shutdown_i, uvlo_i, supply_over_i;
   logic supply_release_i, softstart_done_i, cycle_tick_i, pwm_high_i, hs_over_limit_i;
   logic ls_below_limit_i, window_fault_i, transition_active_i, secondary_i, status_read_i;
   logic discharge_enable_i, overload_retry_enable_i, power_good_transition_blank_i;
   logic power_good_i, power_good_o, power_good_oe_o, switching_o, hs_gate_o, ls_gate_o;
   logic discharge_o, softstart_start_o, ccm_allow_o, overload_retry_flag_o;
   logic current_limit_flag_o, supply_overvoltage_lockout_o, overload;
   int   fails, tests_run, n, k;
   logic [2:0] rows [6] = '{3'h0, 3'h4, 3'h6, 3'h5, 3'h7, 3'h3};
   logic       row_exp [6] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};

   fault_supervisor #(.PAUSE_CYCLES(PAUSE), .FILTER_CYCLES(FILT)) dut (
      .clk_sys_i, .rst_b_i, .enable_i, .thermal_shutdown_i, .uvlo_i, .supply_over_i,
      .supply_release_i, .softstart_done_i, .cycle_tick_i, .pwm_high_i, .hs_over_limit_i,
      .ls_below_limit_i, .window_fault_i, .transition_active_i, .secondary_i,
      .status_read_i, .discharge_enable_i, .overload_retry_enable_i,
      .power_good_transition_blank_i, .power_good_i, .power_good_o, .power_good_oe_o,
      .switching_o, .hs_gate_o, .ls_gate_o, .discharge_o, .softstart_start_o, .ccm_allow_o,
      .overload_retry_flag_o, .current_limit_flag_o, .supply_overvoltage_lockout_o);

   stage_model partner (
      .clk_sys_i, .rst_b_i, .overload_i(overload), .hs_gate_i(hs_gate_o),
      .power_good_oe_i(power_good_oe_o), .hs_over_limit_o(hs_over_limit_i),
      .ls_below_limit_o(ls_below_limit_i), .cycle_tick_o(cycle_tick_i),
      .power_good_wire_o(power_good_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   task automatic stop_test();
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask : chk

   task automatic chk_n(input string name, input int lo, input int hi, input int got);
      tests_run++;
      if (got < lo || got > hi) begin
         fails++;
         $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask : chk_n

   task automatic cyc(input int c);
      repeat (c) @(negedge clk_sys_i);
   endtask : cyc

   task automatic read_status();
      status_read_i = 1'b1;
      cyc(1);
      status_read_i = 1'b0;
      cyc(2);
   endtask : read_status

   // Starts the overload just after a boundary, then counts boundaries until the flag.
   task automatic count_trip(input logic retry, output int cnt);
      while (cycle_tick_i !== 1'b1) cyc(1);
      overload = 1'b1;
      cyc(1);
      cnt = 0;
      for (int i = 0; i < 600; i++) begin
         if ((retry ? overload_retry_flag_o : current_limit_flag_o) === 1'b1) break;
         if (cycle_tick_i === 1'b1) cnt++;
         cyc(1);
      end
   endtask : count_trip

   task automatic do_reset(input logic sec);
      rst_b_i     = 1'b0;
      enable_i    = 1'b0;
      secondary_i = sec;
      cyc(20);
      rst_b_i = 1'b1;
   endtask : do_reset

   initial begin
      #(5000 * 100);
      fails++;
      stop_test();
   end

   initial begin
      {enable_i, thermal_shutdown_i, uvlo_i, supply_over_i, supply_release_i} = 5'h00;
      {softstart_done_i, window_fault_i, transition_active_i, status_read_i} = 4'h0;
      {overload_retry_enable_i, power_good_transition_blank_i, overload} = 3'h0;
      {secondary_i, rst_b_i, fails, tests_run} = '0;
      pwm_high_i         = 1'b1;
      discharge_enable_i = 1'b1;
      do_reset(1'b0);
      chk("pg_oe_reset", 1'b1, power_good_oe_o);
      chk("discharge_reset", 1'b0, discharge_o);
      chk("switching_reset", 1'b0, switching_o);
      enable_i = 1'b1;
      cyc(3);
      chk("switching_start", 1'b1, switching_o);
      chk("pg_oe_softstart", 1'b1, power_good_oe_o);
      softstart_done_i = 1'b1;
      cyc(FILT + 6);
      chk("pg_oe_run", 1'b0, power_good_oe_o);
      chk("pg_level", 1'b0, power_good_o);
      for (int r = 0; r < 6; r++) begin
         {window_fault_i, power_good_transition_blank_i, transition_active_i} = rows[r];
         cyc(FILT + 6);
         chk("pg_oe_row", row_exp[r], power_good_oe_o);
      end
      {window_fault_i, power_good_transition_blank_i, transition_active_i} = 3'h4;
      cyc(FILT + 6);
      window_fault_i = 1'b0;
      cyc(FILT - 2);
      chk("pg_oe_deglitch_rise", 1'b1, power_good_oe_o);
      cyc(6);
      chk("pg_oe_regained", 1'b0, power_good_oe_o);
      window_fault_i = 1'b1;
      cyc(FILT - 2);
      chk("pg_oe_glitch_mid", 1'b0, power_good_oe_o);
      window_fault_i = 1'b0;
      cyc(1);
      window_fault_i = 1'b1;
      cyc(1);
      window_fault_i = 1'b0;
      cyc(FILT + 4);
      chk("pg_oe_glitch", 1'b0, power_good_oe_o);
      overload = 1'b1;
      for (int i = 0; i < 20 && hs_over_limit_i !== 1'b1; i++) cyc(1);
      cyc(1);
      chk("hs_gate_limit", 1'b0, hs_gate_o);
      chk("ls_gate_limit", 1'b1, ls_gate_o);
      cyc(1);
      chk("hs_gate_wait_low", 1'b0, hs_gate_o);
      overload = 1'b0;
      cyc(24);
      count_trip(1'b0, n);
      chk_n("limit_cycles", 4, 4, n);
      cyc(80);
      chk("switching_cont", 1'b1, switching_o);
      chk("retry_flag_cont", 1'b0, overload_retry_flag_o);
      read_status();
      chk("limit_flag_held", 1'b1, current_limit_flag_o);
      overload = 1'b0;
      cyc(24);
      read_status();
      chk("limit_flag_cleared", 1'b0, current_limit_flag_o);
      overload_retry_enable_i = 1'b1;
      cyc(2);
      count_trip(1'b1, n);
      chk_n("retry_cycles", 32, 32, n);
      chk("switching_pause", 1'b0, switching_o);
      k = 0;
      overload = 1'b0;
      status_read_i = 1'b1;
      while (softstart_start_o !== 1'b1 && k < 100) begin
         cyc(1);
         status_read_i = 1'b0;
         k++;
      end
      chk_n("pause_clocks", PAUSE - 1, PAUSE + 1, k);
      chk("retry_flag_held", 1'b1, overload_retry_flag_o);
      chk("pg_oe_retry", 1'b1, power_good_oe_o);
      cyc(FILT + 30);
      chk("pg_oe_recovered", 1'b0, power_good_oe_o);
      read_status();
      chk("retry_flag_cleared", 1'b0, overload_retry_flag_o);
      supply_over_i = 1'b1;
      cyc(3);
      chk("switching_lockout", 1'b0, switching_o);
      chk("lockout_state", 1'b1, supply_overvoltage_lockout_o);
      chk("discharge_lockout", 1'b1, discharge_o);
      chk("pg_oe_lockout", 1'b1, power_good_oe_o);
      supply_over_i    = 1'b0;
      supply_release_i = 1'b1;
      for (int i = 0; i < 5 && softstart_start_o !== 1'b1; i++) cyc(1);
      chk("restart_lockout", 1'b1, softstart_start_o);
      supply_release_i   = 1'b0;
      discharge_enable_i = 1'b0;
      cyc(FILT + 30);
      thermal_shutdown_i = 1'b1;
      cyc(3);
      chk("switching_hot", 1'b0, switching_o);
      chk("discharge_off", 1'b0, discharge_o);
      chk("pg_oe_hot", 1'b1, power_good_oe_o);
      thermal_shutdown_i = 1'b0;
      softstart_done_i   = 1'b0;
      do_reset(1'b1);
      enable_i = 1'b1;
      cyc(3);
      chk("ccm_secondary_ss", 1'b0, ccm_allow_o);
      softstart_done_i = 1'b1;
      cyc(10);
      chk("ccm_secondary_run", 1'b1, ccm_allow_o);
      stop_test();
   end
endmodule : converter_fault_power_good_supervisor_test
